// ---- effecter_pkg.sv ----
package effecter_pkg;

  // Command selectors for the first request byte.
  localparam logic [7:0] CMD_STATE_WRITE   = 8'h01;
  localparam logic [7:0] CMD_STATE_READ    = 8'h02;

  // Result codes.
  localparam logic [7:0] RC_SUCCESS        = 8'h00;
  localparam logic [7:0] RC_BAD_DATA       = 8'h03;
  localparam logic [7:0] RC_BAD_COMMAND    = 8'h05;
  localparam logic [7:0] RC_UNKNOWN_HANDLE = 8'h80;
  localparam logic [7:0] RC_BAD_STATE      = 8'h81;
  localparam logic [7:0] RC_UNSUPPORTED    = 8'h82;

  // Reserved handles and component count limits.
  localparam logic [15:0] HANDLE_RSV_LO    = 16'h0000;
  localparam logic [15:0] HANDLE_RSV_HI    = 16'hffff;
  localparam logic [7:0]  COUNT_MIN        = 8'h01;
  localparam logic [7:0]  COUNT_MAX        = 8'h08;
  localparam int          MAX_COMP         = 8;

  // Operational condition codes.
  localparam logic [7:0] OP_ENABLED_PEND   = 8'h00;
  localparam logic [7:0] OP_ENABLED_IDLE   = 8'h01;
  localparam logic [7:0] OP_DISABLED       = 8'h02;
  localparam logic [7:0] OP_UNAVAILABLE    = 8'h03;

  // Change request codes and the unknown state value.
  localparam logic [7:0] CHG_LEAVE_AS_IS   = 8'h00;
  localparam logic [7:0] CHG_APPLY_TARGET  = 8'h01;
  localparam logic [7:0] STATE_UNKNOWN     = 8'h00;

  // Request buffer depth: selector, handle, count and eight entries.
  localparam logic [4:0] RX_MAX            = 5'd20;
  localparam logic [4:0] RX_READ_LEN       = 5'd3;
  localparam logic [4:0] RX_HDR_LEN        = 5'd4;

  // Register byte addresses.
  localparam logic [7:0] REG_HANDLE        = 8'h00;
  localparam logic [7:0] REG_COUNT         = 8'h04;
  localparam logic [7:0] REG_STATUS        = 8'h08;
  localparam logic [7:0] REG_DONE          = 8'h0c;
  localparam logic [2:0] REG_OPCFG_PAGE    = 3'h1;
  localparam logic [2:0] REG_STATE_PAGE    = 3'h2;

  // Reset values.
  localparam logic [15:0] HANDLE_RST       = 16'h0001;
  localparam logic [3:0]  COUNT_RST        = 4'h8;
  localparam logic [7:0]  MAXST_RST        = 8'h02;
  localparam logic [7:0]  CURST_RST        = 8'h01;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } byte_beat_t;

  typedef enum logic [1:0] {
    PH_COLLECT = 2'b00,
    PH_EVAL    = 2'b01,
    PH_SEND    = 2'b10
  } phase_t;

endpackage : effecter_pkg

// ---- mgmt_ctrl_model.sv ----
`timescale 1ns/10ps
// Management controller at the far side: sends whole request frames, collects answers.
module mgmt_ctrl_model (
  input  wire logic                     i_mclk,
  input  wire effecter_pkg::byte_beat_t i_tx,
  output effecter_pkg::byte_beat_t      o_rx
);
  logic [7:0] rsp[$];
  logic       got_last;

  initial begin
    o_rx     = '0;
    got_last = 1'b0;
  end

  always @(posedge i_mclk) begin
    if (i_tx.valid) begin
      rsp.push_back(i_tx.data);
      if (i_tx.last) begin
        got_last <= 1'b1;
      end
    end
  end

  // Frames go out whole, fields in order, handle low byte first.
  task automatic exchange(input logic [7:0] req[$], output logic ok);
    int n;
    @(posedge i_mclk);
    rsp.delete();
    got_last = 1'b0;
    for (int k = 0; k < req.size(); k++) begin
      o_rx <= '{valid: 1'b1, data: req[k], last: (k == req.size() - 1)};
      @(posedge i_mclk);
    end
    // The released byte lane shows the inverse of the last byte.
    o_rx <= '{valid: 1'b0, data: ~req[req.size() - 1], last: 1'b0};
    for (n = 0; n < 200 && !got_last; n++) begin
      @(posedge i_mclk);
      #1;
    end
    ok = got_last;
  endtask : exchange
endmodule : mgmt_ctrl_model

// ---- state_effecter_set_get.sv ----
`timescale 1ns/10ps
// Functional notes
// - Handles 0x0000 and 0xffff are reserved and never name an effecter.
// - Component count is one byte, 1 to 8; entries follow in that number.
// - Entries map in order onto component offsets 0 to 7.
// - Leave-as-is keeps the component state and ignores the target byte.
// - Apply-target drives the component toward the entry's target state.
// - Result code is the first response byte; bad handle gives 0x80.
// - Invalid target state gives 0x81; a target for a component that is not enabled gives 0x82.
// - Legal targets depend on each component's configured state set.
// - Read request holds only the handle; response has code, count, entries.
// - Read entry: condition, in-progress state, current state, three bytes.
// - Unless enabled, both state bytes report the unknown state value.
module state_effecter_set_get (
  input  wire logic                    i_mclk,
  input  wire logic                    i_reset_n,
  input  wire effecter_pkg::byte_beat_t i_rx,
  output effecter_pkg::byte_beat_t     o_tx,
  input  wire logic [7:0]              i_addr,
  input  wire logic [31:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [31:0]             o_rdata,
  output logic      [63:0]             o_comp_state,
  output logic      [7:0]              o_comp_pending,
  output logic                         o_busy
);

  effecter_pkg::phase_t     phase_r;
  effecter_pkg::byte_beat_t tx_r;
  logic [7:0]               rx_buf_r [0:19];
  logic [4:0]               rx_cnt_r;
  logic [15:0]              handle_r;
  logic [3:0]               count_r;
  logic [7:0]               rc_r;
  logic [7:0][7:0]          cur_r;
  logic [7:0][7:0]          tgt_r;
  logic [7:0][7:0]          opset_r;
  logic [7:0][7:0]          maxst_r;
  logic [7:0]               pend_r;
  logic [31:0]              rdata_r;
  logic [4:0]               tx_idx_r;
  logic [4:0]               tx_len_r;
  logic [2:0]               comp_r;
  logic [1:0]               sub_r;
  logic [7:0]               cmd;
  logic [15:0]              req_handle;
  logic [7:0]               req_cnt;
  logic                     handle_ok;
  logic [7:0]               rc_nxt;
  logic [7:0]               apply_nxt;
  logic                     bad_chg;
  logic                     bad_st;
  logic                     unsup;
  logic                     len_ok;
  logic [7:0]               enabled;
  logic [7:0]               tx_byte;
  logic [7:0]               done_mask;

  assign o_tx           = tx_r;
  assign o_rdata        = rdata_r;
  assign o_comp_state   = cur_r;
  assign o_comp_pending = pend_r;
  assign done_mask      = (i_wr && i_addr == effecter_pkg::REG_DONE) ? i_wdata[7:0] : 8'h00;

  always_comb begin
    for (int i = 0; i < effecter_pkg::MAX_COMP; i++) begin
      enabled[i] = (opset_r[i] == effecter_pkg::OP_ENABLED_IDLE) ||
                   (opset_r[i] == effecter_pkg::OP_ENABLED_PEND);
    end
  end

  // Request decode and result code selection.
  always_comb begin
    cmd        = rx_buf_r[0];
    req_handle = {rx_buf_r[2], rx_buf_r[1]};
    req_cnt    = rx_buf_r[3];
    handle_ok  = (req_handle != effecter_pkg::HANDLE_RSV_LO) &&
                 (req_handle != effecter_pkg::HANDLE_RSV_HI) &&
                 (req_handle == handle_r);
    len_ok     = (req_cnt >= effecter_pkg::COUNT_MIN) &&
                 (req_cnt <= effecter_pkg::COUNT_MAX) &&
                 (req_cnt <= {4'h0, count_r}) &&
                 ({3'h0, rx_cnt_r} == 8'h04 + {req_cnt[6:0], 1'b0});
    bad_chg    = 1'b0;
    bad_st     = 1'b0;
    unsup      = 1'b0;
    apply_nxt  = 8'h00;
    for (int i = 0; i < effecter_pkg::MAX_COMP; i++) begin
      if (8'(i) < req_cnt) begin
        if (rx_buf_r[4 + 2 * i] == effecter_pkg::CHG_APPLY_TARGET) begin
          apply_nxt[i] = 1'b1;
          if (rx_buf_r[5 + 2 * i] == effecter_pkg::STATE_UNKNOWN ||
              rx_buf_r[5 + 2 * i] > maxst_r[i]) begin
            bad_st = 1'b1;
          end else if (!enabled[i]) begin
            unsup = 1'b1;
          end
        end else if (rx_buf_r[4 + 2 * i] != effecter_pkg::CHG_LEAVE_AS_IS) begin
          bad_chg = 1'b1;
        end
      end
    end
    if (cmd == effecter_pkg::CMD_STATE_WRITE) begin
      if (rx_cnt_r < effecter_pkg::RX_HDR_LEN) begin
        rc_nxt = effecter_pkg::RC_BAD_DATA;
      end else if (!handle_ok) begin
        rc_nxt = effecter_pkg::RC_UNKNOWN_HANDLE;
      end else if (!len_ok || bad_chg) begin
        rc_nxt = effecter_pkg::RC_BAD_DATA;
      end else if (bad_st) begin
        rc_nxt = effecter_pkg::RC_BAD_STATE;
      end else if (unsup) begin
        rc_nxt = effecter_pkg::RC_UNSUPPORTED;
      end else begin
        rc_nxt = effecter_pkg::RC_SUCCESS;
      end
    end else if (cmd == effecter_pkg::CMD_STATE_READ) begin
      if (rx_cnt_r != effecter_pkg::RX_READ_LEN) begin
        rc_nxt = effecter_pkg::RC_BAD_DATA;
      end else if (!handle_ok) begin
        rc_nxt = effecter_pkg::RC_UNKNOWN_HANDLE;
      end else begin
        rc_nxt = effecter_pkg::RC_SUCCESS;
      end
    end else begin
      rc_nxt = effecter_pkg::RC_BAD_COMMAND;
    end
  end

  // Phase sequencing and request collection.
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      phase_r  <= effecter_pkg::PH_COLLECT;
      rx_cnt_r <= 5'd0;
      rc_r     <= effecter_pkg::RC_SUCCESS;
      tx_len_r <= 5'd1;
      o_busy   <= 1'b0;
    end else begin
      unique case (phase_r)
        effecter_pkg::PH_COLLECT: begin
          if (i_rx.valid) begin
            if (rx_cnt_r <= effecter_pkg::RX_MAX) begin
              rx_cnt_r <= rx_cnt_r + 5'd1;
            end
            if (i_rx.last) begin
              phase_r <= effecter_pkg::PH_EVAL;
              o_busy  <= 1'b1;
            end
          end
        end
        effecter_pkg::PH_EVAL: begin
          rc_r    <= rc_nxt;
          phase_r <= effecter_pkg::PH_SEND;
          if (cmd == effecter_pkg::CMD_STATE_READ && rc_nxt == effecter_pkg::RC_SUCCESS) begin
            tx_len_r <= 5'd2 + 5'(3 * count_r);
          end else begin
            tx_len_r <= 5'd1;
          end
        end
        effecter_pkg::PH_SEND: begin
          rx_cnt_r <= 5'd0;
          if (tx_idx_r == tx_len_r - 5'd1) begin
            phase_r <= effecter_pkg::PH_COLLECT;
            o_busy  <= 1'b0;
          end
        end
        default: begin
          phase_r <= effecter_pkg::PH_COLLECT;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (phase_r == effecter_pkg::PH_COLLECT && i_rx.valid && rx_cnt_r < effecter_pkg::RX_MAX) begin
      rx_buf_r[rx_cnt_r] <= i_rx.data;
    end
  end

  // Response byte selection.
  always_comb begin
    if (tx_idx_r == 5'd0) begin
      tx_byte = rc_r;
    end else if (tx_idx_r == 5'd1) begin
      tx_byte = {4'h0, count_r};
    end else if (sub_r == 2'd0) begin
      tx_byte = !enabled[comp_r] ? opset_r[comp_r] :
                pend_r[comp_r] ? effecter_pkg::OP_ENABLED_PEND :
                effecter_pkg::OP_ENABLED_IDLE;
    end else if (!enabled[comp_r]) begin
      tx_byte = effecter_pkg::STATE_UNKNOWN;
    end else if (sub_r == 2'd1 && pend_r[comp_r]) begin
      tx_byte = tgt_r[comp_r];
    end else begin
      tx_byte = cur_r[comp_r];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      tx_r     <= '0;
      tx_idx_r <= 5'd0;
      comp_r   <= 3'd0;
      sub_r    <= 2'd0;
    end else if (phase_r == effecter_pkg::PH_SEND) begin
      tx_r.valid <= 1'b1;
      tx_r.data  <= tx_byte;
      tx_r.last  <= (tx_idx_r == tx_len_r - 5'd1);
      tx_idx_r   <= tx_idx_r + 5'd1;
      if (tx_idx_r >= 5'd2) begin
        if (sub_r == 2'd2) begin
          sub_r  <= 2'd0;
          comp_r <= comp_r + 3'd1;
        end else begin
          sub_r <= sub_r + 2'd1;
        end
      end
    end else begin
      tx_r     <= '0;
      tx_idx_r <= 5'd0;
      comp_r   <= 3'd0;
      sub_r    <= 2'd0;
    end
  end

  // Component state: completion from software, then accepted write requests.
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      cur_r  <= {8{effecter_pkg::CURST_RST}};
      tgt_r  <= '0;
      pend_r <= 8'h00;
    end else begin
      for (int i = 0; i < effecter_pkg::MAX_COMP; i++) begin
        if (done_mask[i] && pend_r[i]) begin
          cur_r[i]  <= tgt_r[i];
          pend_r[i] <= 1'b0;
        end
        if (phase_r == effecter_pkg::PH_EVAL && cmd == effecter_pkg::CMD_STATE_WRITE &&
            rc_nxt == effecter_pkg::RC_SUCCESS && apply_nxt[i]) begin
          tgt_r[i]  <= rx_buf_r[5 + 2 * i];
          pend_r[i] <= 1'b1;
        end
      end
    end
  end

  // Register write port.
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      handle_r <= effecter_pkg::HANDLE_RST;
      count_r  <= effecter_pkg::COUNT_RST;
      opset_r  <= {8{effecter_pkg::OP_ENABLED_IDLE}};
      maxst_r  <= {8{effecter_pkg::MAXST_RST}};
    end else if (i_wr) begin
      if (i_addr == effecter_pkg::REG_HANDLE) begin
        handle_r <= i_wdata[15:0];
      end
      if (i_addr == effecter_pkg::REG_COUNT && i_wdata[3:0] >= 4'h1 && i_wdata[3:0] <= 4'h8) begin
        count_r <= i_wdata[3:0];
      end
      if (i_addr[7:5] == effecter_pkg::REG_OPCFG_PAGE && i_addr[1:0] == 2'b00) begin
        opset_r[i_addr[4:2]] <= i_wdata[7:0];
        maxst_r[i_addr[4:2]] <= i_wdata[15:8];
      end
    end
  end

  // Register read port, data valid only in the cycle after the strobe.
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (i_rd) begin
      if (i_addr == effecter_pkg::REG_HANDLE) begin
        rdata_r <= {16'h0000, handle_r};
      end else if (i_addr == effecter_pkg::REG_COUNT) begin
        rdata_r <= {28'h0000000, count_r};
      end else if (i_addr == effecter_pkg::REG_STATUS) begin
        rdata_r <= {15'h0000, o_busy, pend_r, rc_r};
      end else if (i_addr[7:5] == effecter_pkg::REG_OPCFG_PAGE && i_addr[1:0] == 2'b00) begin
        rdata_r <= {16'h0000, maxst_r[i_addr[4:2]], opset_r[i_addr[4:2]]};
      end else if (i_addr[7:5] == effecter_pkg::REG_STATE_PAGE && i_addr[1:0] == 2'b00) begin
        rdata_r <= {15'h0000, pend_r[i_addr[4:2]], tgt_r[i_addr[4:2]], cur_r[i_addr[4:2]]};
      end else begin
        rdata_r <= 32'h0000_0000;
      end
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  a_reserved_handle: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (phase_r == effecter_pkg::PH_EVAL && rx_cnt_r >= effecter_pkg::RX_READ_LEN &&
     (cmd == effecter_pkg::CMD_STATE_READ || rx_cnt_r >= effecter_pkg::RX_HDR_LEN) &&
     (req_handle == effecter_pkg::HANDLE_RSV_LO || req_handle == effecter_pkg::HANDLE_RSV_HI))
    |=> (rc_r == effecter_pkg::RC_UNKNOWN_HANDLE || rc_r == effecter_pkg::RC_BAD_DATA))
    else $error("Reserved handle not refused.");

  a_count_range: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (phase_r == effecter_pkg::PH_EVAL && cmd == effecter_pkg::CMD_STATE_WRITE &&
     (req_cnt < effecter_pkg::COUNT_MIN || req_cnt > effecter_pkg::COUNT_MAX))
    |=> rc_r != effecter_pkg::RC_SUCCESS)
    else $error("Out of range component count accepted.");

  a_first_resp_byte: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    phase_r == effecter_pkg::PH_EVAL |-> ##2 (tx_r.valid && tx_r.data == rc_r))
    else $error("First response byte is not the result code.");

  a_error_no_change: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (phase_r == effecter_pkg::PH_EVAL && rc_nxt != effecter_pkg::RC_SUCCESS && done_mask == 8'h00)
    |=> ($stable(pend_r) && $stable(tgt_r) && $stable(cur_r)))
    else $error("Component state changed on an error.");

  a_leave_as_is: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (phase_r == effecter_pkg::PH_EVAL && rx_buf_r[4] == effecter_pkg::CHG_LEAVE_AS_IS &&
     !done_mask[0])
    |=> ($stable(pend_r[0]) && $stable(tgt_r[0])))
    else $error("Leave-as-is entry changed component zero.");

  a_apply_target: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (phase_r == effecter_pkg::PH_EVAL && cmd == effecter_pkg::CMD_STATE_WRITE &&
     rc_nxt == effecter_pkg::RC_SUCCESS && rx_buf_r[4] == effecter_pkg::CHG_APPLY_TARGET)
    |=> (pend_r[0] && tgt_r[0] == $past(rx_buf_r[5])))
    else $error("Apply-target entry not taken by component zero.");

  a_bad_state: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (phase_r == effecter_pkg::PH_EVAL && cmd == effecter_pkg::CMD_STATE_WRITE && handle_ok &&
     rx_cnt_r >= effecter_pkg::RX_HDR_LEN && rx_buf_r[4] == effecter_pkg::CHG_APPLY_TARGET &&
     rx_buf_r[5] > maxst_r[0])
    |=> (rc_r == effecter_pkg::RC_BAD_STATE || rc_r == effecter_pkg::RC_BAD_DATA))
    else $error("Target beyond the state set not refused.");

  a_unknown_report: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (phase_r == effecter_pkg::PH_SEND && tx_idx_r >= 5'd2 && sub_r != 2'd0 && !enabled[comp_r])
    |=> tx_r.data == effecter_pkg::STATE_UNKNOWN)
    else $error("State byte of a non-enabled component is not unknown.");

endmodule : state_effecter_set_get

// ---- state_effecter_set_get_test.sv ----
`timescale 1ns/10ps
module state_effecter_set_get_test;
  logic                     i_mclk;
  logic                     i_reset_n;
  effecter_pkg::byte_beat_t rx;
  effecter_pkg::byte_beat_t tx;
  logic [7:0]               i_addr;
  logic [31:0]              i_wdata;
  logic                     i_wr;
  logic                     i_rd;
  logic [31:0]              o_rdata;
  logic [63:0]              o_comp_state;
  logic [7:0]               o_comp_pending;
  logic                     o_busy;
  logic [63:0]              exp_state;
  int                       fails;
  int                       samples_checked;

  state_effecter_set_get dut (
    .i_mclk         (i_mclk),
    .i_reset_n      (i_reset_n),
    .i_rx           (rx),
    .o_tx           (tx),
    .i_addr         (i_addr),
    .i_wdata        (i_wdata),
    .i_wr           (i_wr),
    .i_rd           (i_rd),
    .o_rdata        (o_rdata),
    .o_comp_state   (o_comp_state),
    .o_comp_pending (o_comp_pending),
    .o_busy         (o_busy)
  );

  mgmt_ctrl_model pm (
    .i_mclk (i_mclk),
    .i_tx   (tx),
    .o_rx   (rx)
  );

  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      fails++;
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr    <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd   <= 1'b0;
    #1;
    check(64'(o_rdata), 64'(exp));
  endtask : rd_chk

  task automatic send(input logic [7:0] req[$]);
    logic ok;
    pm.exchange(req, ok);
    if (!ok) begin
      fails++;
      conclude();
    end
  endtask : send

  // Sends a frame that must be answered with one result byte and no state change.
  task automatic err_case(input logic [7:0] req[$], input logic [7:0] rc);
    send(req);
    check(pm.rsp[0], rc);
    check(o_comp_state, exp_state);
    check(o_comp_pending, 8'h00);
  endtask : err_case

  initial begin
    fails           = 0;
    samples_checked = 0;
    i_reset_n       = 1'b0;
    i_addr          = 8'h00;
    i_wdata         = 32'h0;
    i_wr            = 1'b0;
    i_rd            = 1'b0;
    exp_state       = 64'h0101010101010101;
    repeat (12) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    rd_chk(8'h00, 32'h0000_0001);
    rd_chk(8'h04, 32'h0000_0008);
    rd_chk(8'h20, 32'h0000_0201);
    rd_chk(8'h10, 32'h0000_0000);
    check(o_comp_state, exp_state);
    // Offset 0 left as is with a junk target, offset 1 applies target 2.
    send({8'h01, 8'h01, 8'h00, 8'h02, 8'h00, 8'h05, 8'h01, 8'h02});
    check(pm.rsp[0], 8'h00);
    check(pm.rsp.size(), 1);
    check(o_comp_pending, 8'h02);
    check(o_comp_state, exp_state);
    check(o_busy, 1'b0);
    rd_chk(8'h08, 32'h0000_0200);
    // Read back while offset 1 is still pending.
    send({8'h02, 8'h01, 8'h00});
    check(pm.rsp.size(), 26);
    check({pm.rsp[0], pm.rsp[1]}, 16'h0008);
    check({pm.rsp[2], pm.rsp[3], pm.rsp[4]}, 24'h010101);
    check({pm.rsp[5], pm.rsp[6], pm.rsp[7]}, 24'h000201);
    reg_wr(8'h0c, 32'h0000_0002);
    exp_state[15:8] = 8'h02;
    rd_chk(8'h44, 32'h0000_0202);
    check(o_comp_state, exp_state);
    err_case({8'h01, 8'h00, 8'h00, 8'h01, 8'h01, 8'h02}, 8'h80);
    err_case({8'h01, 8'hff, 8'hff, 8'h01, 8'h01, 8'h02}, 8'h80);
    err_case({8'h01, 8'h00, 8'h01, 8'h01, 8'h01, 8'h02}, 8'h80);
    err_case({8'h02, 8'hff, 8'hff}, 8'h80);
    err_case({8'h01, 8'h01, 8'h00, 8'h00}, 8'h03);
    err_case({8'h01, 8'h01, 8'h00, 8'h09, 8'h01, 8'h02}, 8'h03);
    err_case({8'h01, 8'h01, 8'h00, 8'h01, 8'h01, 8'h00}, 8'h81);
    err_case({8'h01, 8'h01, 8'h00, 8'h01, 8'h01, 8'h03}, 8'h81);
    // A wider state set makes target 3 legal for offset 0.
    reg_wr(8'h20, 32'h0000_0401);
    send({8'h01, 8'h01, 8'h00, 8'h01, 8'h01, 8'h03});
    check(pm.rsp[0], 8'h00);
    check(o_comp_pending, 8'h01);
    reg_wr(8'h0c, 32'h0000_0001);
    exp_state[7:0] = 8'h03;
    rd_chk(8'h40, 32'h0000_0303);
    // Disabled offset 0 refuses a legal target and reads as unknown.
    reg_wr(8'h20, 32'h0000_0402);
    err_case({8'h01, 8'h01, 8'h00, 8'h01, 8'h01, 8'h02}, 8'h82);
    send({8'h02, 8'h01, 8'h00});
    check({pm.rsp[0], pm.rsp[2], pm.rsp[3], pm.rsp[4]}, 32'h0002_0000);
    check({pm.rsp[5], pm.rsp[6], pm.rsp[7]}, 24'h010202);
    err_case({8'h07, 8'h01, 8'h00}, 8'h05);
    err_case({8'h01, 8'h01, 8'h00, 8'h01, 8'h02, 8'h02}, 8'h03);
    // One byte beyond eight leave-as-is entries makes the frame too long.
    err_case({8'h01, 8'h01, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
              8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
              8'h00, 8'h00, 8'h00}, 8'h03);
    // A count register of two refuses a wider write and shortens the read answer.
    reg_wr(8'h04, 32'h0000_0009);
    rd_chk(8'h04, 32'h0000_0008);
    reg_wr(8'h04, 32'h0000_0002);
    rd_chk(8'h04, 32'h0000_0002);
    err_case({8'h01, 8'h01, 8'h00, 8'h03, 8'h00, 8'h00,
              8'h00, 8'h00, 8'h00, 8'h00}, 8'h03);
    send({8'h02, 8'h01, 8'h00});
    check(pm.rsp.size(), 8);
    check({pm.rsp[0], pm.rsp[1]}, 16'h0002);
    check({pm.rsp[5], pm.rsp[6], pm.rsp[7]}, 24'h010202);
    conclude();
  end
endmodule : state_effecter_set_get_test
